/* src/timing_select.sv */
// picks the per-core sampling adjustments for the current mode and phase
`timescale 1ns/1ps
module timing_select
    import trim_pkg::*;
(
    // bank and mode
    input  trim_pkg::bank_t        bank,
    input  trim_pkg::cal_mode_t    mode,
    // selected adjustments
    output trim_pkg::core_timing_t sel
);
    import trim_pkg::*;

    always_comb begin
        sel = '0;
        if (mode.single_channel && !mode.background) begin
            sel.core_a  = bank[SLOT_CORE_A_FG];
            sel.core_b  = bank[SLOT_CORE_B_FG];
            sel.applied = 1'b1;
        end else if (mode.single_channel && mode.background) begin
            sel.core_a      = bank[SLOT_CORE_A_BG];
            sel.core_b      = bank[SLOT_CORE_B_BG];
            sel.core_c      = mode.c_phase_90 ? bank[SLOT_CORE_C_BG_P90] : bank[SLOT_CORE_C_BG_P0];
            sel.core_c_used = 1'b1;
            sel.applied     = 1'b1;
        end
        // dual-channel adjustments live outside this bank: nothing applied
    end
endmodule

/* src/trim_and_timing_adjust_regs.sv */
// AXI4-Lite bank of termination trims and sampling-instant adjustments
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module trim_and_timing_adjust_regs
    import trim_pkg::*;
(
    // clock, reset, enable
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   clk_en,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0]      awaddr,
    input  wire logic [2:0]             awprot,
    input  wire logic                   awvalid,
    output logic                        awready,
    // axi4-lite write data
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    // axi4-lite write response
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0]      araddr,
    input  wire logic [2:0]             arprot,
    input  wire logic                   arvalid,
    output logic                        arready,
    // axi4-lite read data
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    // factory trim store and calibration mode
    input  trim_pkg::bank_t             factory_trim,
    input  trim_pkg::cal_mode_t         cal_mode,
    // trims and selected adjustments
    output trim_pkg::trim_t             input_a_termination_trim,
    output trim_pkg::trim_t             input_b_termination_trim,
    output trim_pkg::core_timing_t      core_timing
);
    import trim_pkg::*;

    localparam state_t STATE_RESET = '{
        bank:         '0,
        load_pending: 1'b1,
        awready:      1'b0,
        wready:       1'b0,
        arready:      1'b0,
        aw_got:       1'b0,
        w_got:        1'b0,
        awaddr:       '0,
        wdata:        TRIM_CLEAR,
        wstrb0:       1'b0,
        bvalid:       1'b0,
        bresp:        RESP_OKAY,
        rvalid:       1'b0,
        rresp:        RESP_OKAY,
        rdata:        TRIM_CLEAR,
        timing:       '0
    };

    state_t             st_q;
    state_t             st_d;
    core_timing_t       sel;

    logic               aw_hs;
    logic               w_hs;
    logic               ar_hs;
    logic               wr_fire;
    logic [ADDR_W-1:0]  wr_addr;
    trim_t              wr_byte;
    logic               wr_strb0;
    logic [3:0]         wr_dec;
    logic [3:0]         rd_dec;
    bank_t              keep_mask;

    timing_select u_timing_select (
        .bank (st_q.bank),
        .mode (cal_mode),
        .sel  (sel)
    );

    // channel handshakes and merged write beat
    always_comb begin
        aw_hs    = awvalid && st_q.awready;
        w_hs     = wvalid && st_q.wready;
        ar_hs    = arvalid && st_q.arready;
        wr_addr  = st_q.aw_got ? st_q.awaddr : awaddr;
        wr_byte  = st_q.w_got ? st_q.wdata : wdata[7:0];
        wr_strb0 = st_q.w_got ? st_q.wstrb0 : wstrb[0];
        wr_fire  = (st_q.aw_got || aw_hs) && (st_q.w_got || w_hs);
        wr_dec   = decode_slot(wr_addr);
        rd_dec   = decode_slot(araddr);
        keep_mask = '1;
        if (wr_fire && wr_dec[3] && wr_strb0) begin
            keep_mask[wr_dec[2:0]] = TRIM_CLEAR;
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.timing = sel;
        if (st_q.load_pending) begin
            // factory contents land on the first edge with clk_en high after release
            st_d.bank         = factory_trim;
            st_d.load_pending = 1'b0;
            st_d.awready      = 1'b1;
            st_d.wready       = 1'b1;
            st_d.arready      = 1'b1;
        end else begin
            if (aw_hs) begin
                st_d.awready = 1'b0;
                st_d.aw_got  = 1'b1;
                st_d.awaddr  = awaddr;
            end
            if (w_hs) begin
                st_d.wready = 1'b0;
                st_d.w_got  = 1'b1;
                st_d.wdata  = wdata[7:0];
                st_d.wstrb0 = wstrb[0];
            end
            if (wr_fire) begin
                st_d.aw_got = 1'b0;
                st_d.w_got  = 1'b0;
                st_d.bvalid = 1'b1;
                st_d.bresp  = wr_dec[3] ? RESP_OKAY : RESP_SLVERR;
                // only lane 0 carries data; one slot changes
                if (wr_dec[3] && wr_strb0) begin
                    st_d.bank[wr_dec[2:0]] = wr_byte;
                end
            end
            if (st_q.bvalid && bready) begin
                st_d.bvalid  = 1'b0;
                st_d.awready = 1'b1;
                st_d.wready  = 1'b1;
            end
            if (ar_hs) begin
                st_d.arready = 1'b0;
                st_d.rvalid  = 1'b1;
                st_d.rresp   = rd_dec[3] ? RESP_OKAY : RESP_SLVERR;
                st_d.rdata   = rd_dec[3] ? st_q.bank[rd_dec[2:0]] : TRIM_CLEAR;
            end
            if (st_q.rvalid && rready) begin
                st_d.rvalid  = 1'b0;
                st_d.arready = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= STATE_RESET;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign awready                  = st_q.awready;
    assign wready                   = st_q.wready;
    assign bvalid                   = st_q.bvalid;
    assign bresp                    = st_q.bresp;
    assign arready                  = st_q.arready;
    assign rvalid                   = st_q.rvalid;
    assign rresp                    = st_q.rresp;
    assign rdata                    = {RDATA_PAD, st_q.rdata};
    assign input_a_termination_trim = st_q.bank[SLOT_INPUT_A_TERM];
    assign input_b_termination_trim = st_q.bank[SLOT_INPUT_B_TERM];
    assign core_timing              = st_q.timing;

    // checks
    sequence s_write_commit;
        clk_en && wr_fire && !st_q.load_pending;
    endsequence

    sequence s_read_taken;
        clk_en && ar_hs && !st_q.load_pending;
    endsequence

    property p_write_slot(logic [2:0] slot);
        @(posedge aclk) disable iff (!aresetn)
        s_write_commit ##0 (wr_dec[3] && wr_strb0 && wr_dec[2:0] == slot)
            |=> st_q.bank[slot] == $past(wr_byte);
    endproperty

    a_factory_load: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && clk_en && st_q.load_pending |=> st_q.bank == $past(factory_trim) && awready && arready)
        else $error("factory trims not loaded after reset");

    a_write_input_a: assert property (p_write_slot(SLOT_INPUT_A_TERM))
        else $error("first input trim write lost");

    a_write_input_b: assert property (p_write_slot(SLOT_INPUT_B_TERM))
        else $error("second input trim write lost");

    a_neighbours_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        s_write_commit |=> (st_q.bank & $past(keep_mask)) == ($past(st_q.bank) & $past(keep_mask)))
        else $error("write disturbed a neighbouring register");

    a_read_back: assert property (@(posedge aclk) disable iff (!aresetn)
        s_read_taken ##0 rd_dec[3]
            |=> rvalid && rresp == RESP_OKAY && rdata[7:0] == $past(st_q.bank[rd_dec[2:0]]))
        else $error("read did not return register contents");

    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_write_commit |=> bvalid && !awready && !wready ##0 (bvalid || !clk_en) [*1])
        else $error("write response missing");

    a_fg_select: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && clk_en && cal_mode.single_channel && !cal_mode.background
            |=> core_timing.applied && core_timing.core_a == $past(st_q.bank[SLOT_CORE_A_FG])
                && core_timing.core_b == $past(st_q.bank[SLOT_CORE_B_FG]) && !core_timing.core_c_used)
        else $error("foreground adjustment not selected");

    a_bg_select_ac: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && clk_en && cal_mode.single_channel && cal_mode.background
            |=> core_timing.core_a == $past(st_q.bank[SLOT_CORE_A_BG]) && core_timing.core_c_used
                && core_timing.core_c == ($past(cal_mode.c_phase_90) ? $past(st_q.bank[SLOT_CORE_C_BG_P90])
                                                                     : $past(st_q.bank[SLOT_CORE_C_BG_P0])))
        else $error("background A or C adjustment not selected");

    a_bg_select_b: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && clk_en && cal_mode.single_channel && cal_mode.background
            |=> core_timing.core_b == $past(st_q.bank[SLOT_CORE_B_BG]))
        else $error("background B adjustment not selected");

    a_dual_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && clk_en && !cal_mode.single_channel |=> !core_timing.applied && !core_timing.core_c_used)
        else $error("adjustment applied outside single-channel mode");

    a_fg_c_unused: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && clk_en && cal_mode.single_channel && !cal_mode.background |=> core_timing.core_c == TRIM_CLEAR)
        else $error("C adjustment driven in foreground mode");

    // core adjustment writes
    a_write_core_a_fg: assert property (p_write_slot(SLOT_CORE_A_FG))
        else $error("foreground A adjustment write lost");

    a_write_core_b_fg: assert property (p_write_slot(SLOT_CORE_B_FG))
        else $error("foreground B adjustment write lost");

    a_write_core_a_bg: assert property (p_write_slot(SLOT_CORE_A_BG))
        else $error("background A adjustment write lost");

    a_write_core_c_p0: assert property (p_write_slot(SLOT_CORE_C_BG_P0))
        else $error("background C phase 0 adjustment write lost");

    a_write_core_c_p90: assert property (p_write_slot(SLOT_CORE_C_BG_P90))
        else $error("background C phase 90 adjustment write lost");

    a_write_core_b_bg: assert property (p_write_slot(SLOT_CORE_B_BG))
        else $error("background B adjustment write lost");

    // register contents
    a_factory_outputs: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && clk_en && st_q.load_pending
            |=> input_a_termination_trim == $past(factory_trim[SLOT_INPUT_A_TERM])
                && input_b_termination_trim == $past(factory_trim[SLOT_INPUT_B_TERM]))
        else $error("factory trims not on the trim outputs");

    a_no_stray_write: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && clk_en && !st_q.load_pending && !wr_fire |=> $stable(st_q.bank))
        else $error("register changed without a write");

    a_masked_write: assert property (@(posedge aclk) disable iff (!aresetn)
        s_write_commit ##0 (wr_dec[3] && !wr_strb0)
            |=> bvalid && bresp == RESP_OKAY && $stable(st_q.bank))
        else $error("write with lane 0 off changed a register");

    a_unmapped_write: assert property (@(posedge aclk) disable iff (!aresetn)
        s_write_commit ##0 !wr_dec[3]
            |=> bvalid && bresp == RESP_SLVERR && $stable(st_q.bank))
        else $error("unmapped write not refused");

    a_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
        s_read_taken ##0 !rd_dec[3]
            |=> rvalid && rresp == RESP_SLVERR && rdata == 32'h00000000)
        else $error("unmapped read not refused");

    a_rdata_pad: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid |-> rdata[31:8] == 24'h000000)
        else $error("read data bits above the trim not zero");

    // bus handshakes and clock enable
    sequence s_write_held;
        bvalid && !bready;
    endsequence

    sequence s_read_held;
        rvalid && !rready;
    endsequence

    a_bresp_stands: assert property (@(posedge aclk) disable iff (!aresetn)
        s_write_held |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");

    a_rresp_stands: assert property (@(posedge aclk) disable iff (!aresetn)
        s_read_held |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read response dropped before rready");

    a_write_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid |-> !awready && !wready)
        else $error("new write accepted while a response is pending");

    a_read_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid |-> !arready)
        else $error("new read accepted while read data is pending");

    a_write_release: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && bvalid && bready |=> !bvalid && awready && wready)
        else $error("write channels not reopened after response");

    a_read_release: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && rvalid && rready |=> !rvalid && arready)
        else $error("read channel not reopened after data");

    a_aw_taken: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && aw_hs |=> !awready)
        else $error("write address accepted twice");

    a_w_taken: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && w_hs |=> !wready)
        else $error("write data accepted twice");

    a_ar_taken: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && ar_hs |=> !arready && rvalid)
        else $error("read address accepted twice");

    a_load_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q.load_pending |-> !awready && !wready && !arready && !bvalid && !rvalid)
        else $error("bus active before factory load");

    a_enable_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && !clk_en |=> $stable(st_q))
        else $error("state moved while the clock enable was low");

endmodule

/* src/trim_pkg.sv */
// constants, carriers and address decode for the trim and timing-adjust bank
package trim_pkg;

    localparam int unsigned ADDR_W   = 12;
    localparam int unsigned NUM_REGS = 8;

    // register indices; the byte address is four times the index
    localparam logic [9:0] IDX_INPUT_A_TERM   = 10'h07E;
    localparam logic [9:0] IDX_INPUT_B_TERM   = 10'h07F;
    localparam logic [9:0] IDX_CORE_A_FG      = 10'h080;
    localparam logic [9:0] IDX_CORE_B_FG      = 10'h081;
    localparam logic [9:0] IDX_CORE_A_BG      = 10'h082;
    localparam logic [9:0] IDX_CORE_C_BG_P0   = 10'h083;
    localparam logic [9:0] IDX_CORE_C_BG_P90  = 10'h084;
    localparam logic [9:0] IDX_CORE_B_BG      = 10'h085;

    // slots inside the bank, in index order
    localparam logic [2:0] SLOT_INPUT_A_TERM  = 3'h0;
    localparam logic [2:0] SLOT_INPUT_B_TERM  = 3'h1;
    localparam logic [2:0] SLOT_CORE_A_FG     = 3'h2;
    localparam logic [2:0] SLOT_CORE_B_FG     = 3'h3;
    localparam logic [2:0] SLOT_CORE_A_BG     = 3'h4;
    localparam logic [2:0] SLOT_CORE_C_BG_P0  = 3'h5;
    localparam logic [2:0] SLOT_CORE_C_BG_P90 = 3'h6;
    localparam logic [2:0] SLOT_CORE_B_BG     = 3'h7;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] TRIM_CLEAR  = 8'h00;
    localparam logic [23:0] RDATA_PAD  = 24'h000000;

    typedef logic [7:0]          trim_t;
    typedef trim_t [NUM_REGS-1:0] bank_t;

    typedef struct packed {
        logic single_channel;
        logic background;
        logic c_phase_90;
    } cal_mode_t;

    typedef struct packed {
        trim_t core_a;
        trim_t core_b;
        trim_t core_c;
        logic  core_c_used;
        logic  applied;
    } core_timing_t;

    typedef struct packed {
        bank_t              bank;
        logic               load_pending;
        logic               awready;
        logic               wready;
        logic               arready;
        logic               aw_got;
        logic               w_got;
        logic [ADDR_W-1:0]  awaddr;
        trim_t              wdata;
        logic               wstrb0;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [1:0]         rresp;
        trim_t              rdata;
        core_timing_t       timing;
    } state_t;

    // {hit, slot} for a byte address
    function automatic logic [3:0] decode_slot(input logic [ADDR_W-1:0] addr);
        logic [9:0] idx;
        logic [9:0] rel;
        idx = addr[ADDR_W-1:2];
        rel = idx - IDX_INPUT_A_TERM;
        if (idx >= IDX_INPUT_A_TERM && idx <= IDX_CORE_B_BG) begin
            decode_slot = {1'b1, rel[2:0]};
        end else begin
            decode_slot = 4'h0;
        end
    endfunction

endpackage

/* testbench/trim_and_timing_adjust_regs_bench.sv */
// self-checking bench for the trim and timing-adjust register bank
`timescale 1ns/1ps
module trim_and_timing_adjust_regs_bench;
    import trim_pkg::*;
    logic aclk, aresetn, clk_en, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [2:0]   awprot, arprot;
    logic [31:0]  wdata, rdata;
    logic [3:0]   wstrb;
    logic [1:0]   bresp, rresp;
    bank_t        factory_trim;
    cal_mode_t    cal_mode;
    trim_t        trim_a, trim_b;
    core_timing_t core_timing;
    logic [7:0]   model [NUM_REGS];
    int           n_fail, samples_checked, cycles;
    logic [31:0]  rd;
    logic [1:0]   rs;

    trim_and_timing_adjust_regs trim_and_timing_adjust_regs_i (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .factory_trim(factory_trim), .cal_mode(cal_mode),
        .input_a_termination_trim(trim_a), .input_b_termination_trim(trim_b),
        .core_timing(core_timing)
    );

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic complete_run();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("[FAIL] %0t timeout", $time);
            complete_run();
        end
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_timing(input core_timing_t exp);
        samples_checked++;
        if (core_timing !== exp) begin
            n_fail++;
            $display("[FAIL] %0t core timing got %h expected %h", $time, core_timing, exp);
        end
    endtask

    function automatic logic [ADDR_W-1:0] addr_of(input int i);
        return {IDX_INPUT_A_TERM, 2'b00} + ADDR_W'(4 * i);
    endfunction

    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
        end
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        for (int i = 0; i < NUM_REGS; i++) begin
            factory_trim[i] <= 8'($urandom);
        end
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < NUM_REGS; i++) model[i] = factory_trim[i];
        @(posedge aclk);
    endtask

    task automatic read_all();
        for (int i = 0; i < NUM_REGS; i++) begin
            axi_read(addr_of(i), rd, rs);
            chk_val(rd, {24'h000000, model[i]}, "read data");
            chk_val(32'(rs), 32'(RESP_OKAY), "read resp");
        end
    endtask

    function automatic core_timing_t exp_timing(input cal_mode_t m);
        core_timing_t e;
        e = '0;
        if (m.single_channel && !m.background) begin
            e = {model[2], model[3], 8'h00, 1'b0, 1'b1};
        end else if (m.single_channel) begin
            e = {model[4], model[7], m.c_phase_90 ? model[6] : model[5], 1'b1, 1'b1};
        end
        return e;
    endfunction

    task automatic check_modes();
        for (int m = 0; m < 8; m++) begin
            @(posedge aclk);
            cal_mode <= cal_mode_t'(m);
            repeat (3) @(posedge aclk);
            chk_timing(exp_timing(cal_mode_t'(m)));
        end
    endtask

    task automatic check_freeze();
        cal_mode_t prev;
        prev = cal_mode;
        @(posedge aclk);
        clk_en   <= 1'b0;
        cal_mode <= cal_mode_t'(3'(prev) ^ 3'h7);
        repeat (4) @(posedge aclk);
        chk_timing(exp_timing(prev));
        chk_val({trim_a, trim_b}, {model[0], model[1]}, "trims frozen");
        clk_en <= 1'b1;
        repeat (3) @(posedge aclk);
        chk_timing(exp_timing(cal_mode));
    endtask

    initial begin
        void'($urandom(32'h32a49884));
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        clk_en = 1'b1;
        {awprot, arprot, awaddr, araddr, wdata, wstrb} = '0;
        cal_mode = '0;
        factory_trim = '0;
        do_reset();
        read_all();
        check_modes();
        check_freeze();
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                model[i] = 8'($urandom);
                axi_write(addr_of(i), {24'($urandom), model[i]}, 4'hF, rs);
                chk_val(32'(rs), 32'(RESP_OKAY), "write resp");
                chk_val({trim_a, trim_b}, {model[0], model[1]}, "trim outputs");
            end
        end
        axi_write(addr_of(3), 32'h000000A5, 4'hE, rs);
        chk_val(32'(rs), 32'(RESP_OKAY), "masked write resp");
        axi_write(12'h1F4, 32'h0000005A, 4'hF, rs);
        chk_val(32'(rs), 32'(RESP_SLVERR), "unmapped write resp");
        axi_write(12'h218, 32'h0000005A, 4'hF, rs);
        chk_val(32'(rs), 32'(RESP_SLVERR), "unmapped write resp");
        axi_read(12'h000, rd, rs);
        chk_val({rd[29:0], rs}, 32'(RESP_SLVERR), "unmapped read");
        read_all();
        check_modes();
        do_reset();
        read_all();
        chk_val({trim_a, trim_b}, {model[0], model[1]}, "trim after reset");
        check_modes();
        complete_run();
    end
endmodule
